// ---- hw/eeprom_read_seq.sv ----
// Two-wire EEPROM slave: select decode, address load and read sequencing
//
// Summary of operation
// - Counter steps after every transmitted byte
// - Read select acked, then byte at counter
// - Sequential read only by master acknowledging
// - Master ack sends next byte, no command
// - Counter wraps past last address to zero
// - Release data line, sample ninth-clock ack
// - No ack means stop and go idle
// - Respond only when chip-select bits match pins
// - Dummy write loads two address bytes first
// - Sixteen-bit address, high byte first, top ignored
`timescale 1ns/10ps
`default_nettype none
module eeprom_read_seq
    import eeprom_rd_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'h5 // Device type code, value arbitrary
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output var logic sda_out,
    output var logic sda_oe,
    input wire logic chip_select_pin_0,
    input wire logic chip_select_pin_1,
    input wire logic chip_select_pin_2,
    output wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_rdata,
    output wire logic wr_valid,
    output wire logic [WQ_W-1:0] wr_data,
    input wire logic wr_ready
);
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic scl_prev;
    logic sda_prev;
    seq_state_e state;
    rx_kind_e kind;
    logic [3:0] bit_cnt;
    logic [DATA_W-1:0] rx_byte;
    logic [DATA_W-1:0] tx_sh;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_HI_W-1:0] addr_hi;
    logic ack_seen;

    wq_if #(.W(WQ_W)) wq ();

    wq_fifo #(.WIDTH(WQ_W), .DEPTH(WQ_DEPTH)) u_wq (
        .clk(clk),
        .srst(srst),
        .q(wq)
    );

    // Pin synchroniser, first stage read only by second
    wire [PIN_N-1:0] pin_raw = {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0,
                                sda_in, scl_in};
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            scl_prev <= pin_sync[PIN_SCL];
            sda_prev <= pin_sync[PIN_SDA];
        end
    end

    // Bus event decode
    wire scl = pin_sync[PIN_SCL];
    wire sda = pin_sync[PIN_SDA];
    wire [2:0] cs_pins = pin_sync[PIN_CS_HI:PIN_CS_LO];
    wire scl_rise = scl && !scl_prev;
    wire scl_fall = !scl && scl_prev;
    wire start_det = scl && scl_prev && sda_prev && !sda;
    wire stop_det = scl && scl_prev && !sda_prev && sda;

    // Byte and select decode
    wire rx_done = bit_cnt == BITS_PER_BYTE;
    wire is_read = rx_byte[RW_BIT];
    wire sel_match = (rx_byte[TYPE_HI:TYPE_LO] == DEV_TYPE)
                     && (rx_byte[CS_HI:CS_LO] == cs_pins);
    wire rx_ack = (kind == K_SEL) ? sel_match :
                  (kind == K_WDATA) ? wq.in_ready : 1'b1;
    wire [ADDR_W-1:0] addr_inc = addr + ADDR_STEP;
    wire tx_end = (state == ST_TX) && scl_fall && (bit_cnt == LAST_TX_BIT);
    wire rx_byte_end = (state == ST_RX) && scl_fall && rx_done;

    // Write-path queue: full queue refuses the byte with NoAck
    assign wq.in_valid = rx_byte_end && (kind == K_WDATA) && wq.in_ready;
    assign wq.in_data = {addr, rx_byte};
    assign wq.out_ready = wr_ready;
    assign wr_valid = wq.out_valid;
    assign wr_data = wq.out_data;
    assign mem_addr = addr;

    // Open-drain level, held constant
    always_ff @(posedge clk) begin
        if (srst) sda_out <= 1'b0;
        else sda_out <= SDA_DRIVE_LEVEL;
    end

    // Transfer sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            kind <= K_SEL;
            bit_cnt <= BIT_RESET;
            rx_byte <= '0;
            tx_sh <= '0;
            addr <= ADDR_RESET;
            addr_hi <= '0;
            sda_oe <= 1'b0;
            ack_seen <= 1'b0;
        end else if (start_det) begin
            state <= ST_RX;
            kind <= K_SEL;
            bit_cnt <= BIT_RESET;
            sda_oe <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise && !rx_done) begin
                        rx_byte <= {rx_byte[DATA_W-2:0], sda};
                        bit_cnt <= bit_cnt + BIT_STEP;
                    end else if (rx_byte_end) begin
                        state <= rx_ack ? ST_RX_ACK : ST_IDLE;
                        sda_oe <= rx_ack;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= BIT_RESET;
                        state <= ST_RX;
                        unique case (kind)
                            K_SEL: begin
                                if (is_read) begin
                                    state <= ST_TX;
                                    tx_sh <= mem_rdata;
                                end else begin
                                    kind <= K_ADDR_HI;
                                end
                            end
                            K_ADDR_HI: begin
                                addr_hi <= rx_byte[ADDR_HI_W-1:0];
                                kind <= K_ADDR_LO;
                            end
                            K_ADDR_LO: begin
                                addr <= {addr_hi, rx_byte};
                                kind <= K_WDATA;
                            end
                            K_WDATA: begin
                                kind <= K_WDATA;
                            end
                        endcase
                        sda_oe <= (kind == K_SEL) && is_read && !mem_rdata[DATA_W-1];
                    end
                end
                ST_TX: begin
                    if (tx_end) begin
                        state <= ST_TX_ACK;
                        sda_oe <= 1'b0;
                        addr <= addr_inc;
                    end else if (scl_fall) begin
                        bit_cnt <= bit_cnt + BIT_STEP;
                        tx_sh <= {tx_sh[DATA_W-2:0], 1'b0};
                        sda_oe <= !tx_sh[DATA_W-2];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_seen <= !sda;
                    end else if (scl_fall && ack_seen) begin
                        state <= ST_TX;
                        bit_cnt <= BIT_RESET;
                        tx_sh <= mem_rdata;
                        sda_oe <= !mem_rdata[DATA_W-1];
                    end else if (scl_fall) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_addr_step: assert property (tx_end |=> addr == $past(addr) + ADDR_STEP)
        else $error("address did not step after byte");
    a_addr_wrap: assert property (tx_end && (addr == '1) |=> addr == ADDR_RESET)
        else $error("address did not wrap to zero");
    a_read_first: assert property ((state == ST_RX_ACK) && scl_fall && (kind == K_SEL)
        && is_read |=> (state == ST_TX) && (tx_sh == $past(mem_rdata))
        && (sda_oe == !$past(mem_rdata[DATA_W-1])))
        else $error("read select did not start byte output");
    a_ack_next: assert property ((state == ST_TX_ACK) && scl_fall && ack_seen
        |=> (state == ST_TX) && (bit_cnt == BIT_RESET))
        else $error("acked byte not followed by next byte");
    a_ack_release: assert property ((state == ST_TX_ACK) |-> !sda_oe)
        else $error("data line driven in ack slot");
    a_nack_idle: assert property ((state == ST_TX_ACK) && scl_fall && !ack_seen
        |=> (state == ST_IDLE) ##1 !sda_oe)
        else $error("NoAck did not end transfer");
    a_cs_mismatch: assert property (rx_byte_end && (kind == K_SEL) && !sel_match
        |=> (state == ST_IDLE) && !sda_oe)
        else $error("unmatched select was answered");
    a_stop_abort: assert property (stop_det |=> (state == ST_IDLE) && !sda_oe)
        else $error("STOP did not return to idle");
    a_start_select: assert property (start_det |=> (state == ST_RX) && (kind == K_SEL)
        && (bit_cnt == BIT_RESET) && !sda_oe)
        else $error("START did not await select byte");
    a_addr_load: assert property ((state == ST_RX_ACK) && scl_fall && (kind == K_ADDR_LO)
        |=> addr == {$past(addr_hi), $past(rx_byte)})
        else $error("address bytes not loaded");
endmodule : eeprom_read_seq
`default_nettype wire

// ---- hw/eeprom_rd_pkg.sv ----
// Shared constants and types for the serial EEPROM read sequencer
package eeprom_rd_pkg;
    // Address counter spans the larger memory depth
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int ADDR_HI_W = ADDR_W - DATA_W;
    // Write queue carries {address, data}
    localparam int WQ_W = ADDR_W + DATA_W;
    localparam int WQ_DEPTH = 16;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [3:0] BIT_RESET = 4'h0;
    // Select byte fields
    localparam int RW_BIT = 0;
    localparam int TYPE_HI = 7;
    localparam int TYPE_LO = 4;
    localparam int CS_HI = 3;
    localparam int CS_LO = 1;
    // Pin synchroniser lanes
    localparam int PIN_N = 5;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_CS_LO = 2;
    localparam int PIN_CS_HI = 4;
    localparam logic [PIN_N-1:0] PIN_IDLE = 5'h03;
    // Open-drain pin only ever pulls low
    localparam logic SDA_DRIVE_LEVEL = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX     = 3'b011,
        ST_TX_ACK = 3'b100
    } seq_state_e;

    typedef enum logic [1:0] {
        K_SEL     = 2'b00,
        K_ADDR_HI = 2'b01,
        K_ADDR_LO = 2'b10,
        K_WDATA   = 2'b11
    } rx_kind_e;
endpackage : eeprom_rd_pkg

// ---- hw/wq_if.sv ----
// Valid/ready carrier between the sequencer and its write queue
`timescale 1ns/10ps
`default_nettype none
interface wq_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport owner (output in_valid, output in_data, input in_ready,
                   input out_valid, input out_data, output out_ready);
    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
endinterface : wq_if
`default_nettype wire

// ---- hw/wq_fifo.sv ----
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module wq_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    wq_if.store q
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_FILL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] PTR_STEP = PW'(1);
    localparam logic [PW:0] FILL_STEP = (PW+1)'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] fill;

    // Handshake decode and honest full/empty
    wire push = q.in_valid && q.in_ready;
    wire pop = q.out_valid && q.out_ready;
    assign q.in_ready = fill != FULL_FILL;
    assign q.out_valid = fill != '0;
    assign q.out_data = mem[rd_ptr];

    // Storage write, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= q.in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + PTR_STEP;
            if (pop) rd_ptr <= rd_ptr + PTR_STEP;
            if (push && !pop) fill <= fill + FILL_STEP;
            else if (pop && !push) fill <= fill - FILL_STEP;
        end
    end
endmodule : wq_fifo
`default_nettype wire

// ---- tb/two_wire_master.sv ----
// Two-wire bus master model that issues transfers to the sequencer
`timescale 1ns/10ps
`default_nettype none
module two_wire_master #(
    parameter int PU_NS = 200000
) (
    output var logic scl,
    output var logic sda_low,
    input wire logic sda
);
    // Bus clock stands high and data is released outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // START, also a repeated START from a low clock
    // Power-up wait; the quarter-ns phase keeps every link edge off the clock edge
    task automatic start();
        if ($time < PU_NS) #(PU_NS - $time + 2.25);
        #10 sda_low = 1'b0;
        #52.5 scl = 1'b1;
        #31 sda_low = 1'b1;
        #31.5 scl = 1'b0;
    endtask : start
    // STOP, leaving the bus idle
    task automatic stop();
        #10 sda_low = 1'b1;
        #52.5 scl = 1'b1;
        #31 sda_low = 1'b0;
        #62.5;
    endtask : stop
    // One clock pulse: data set while low, wire sampled while high
    task automatic clk_bit(input logic b, output logic s);
        #10 sda_low = !b;
        #52.5 scl = 1'b1;
        #31 s = sda;
        #31.5 scl = 1'b0;
    endtask : clk_bit
    // Eight bits MSB first, then the ninth slot
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic s9);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], q[i]);
        end
        clk_bit(a, s9);
    endtask : xfer
endmodule : two_wire_master
`default_nettype wire

// ---- tb/test_serial_eeprom_read_sequencer.sv ----
// Self-checking bench for the serial EEPROM read sequencer
`timescale 1ns/10ps
`default_nettype none
module test_serial_eeprom_read_sequencer
    import eeprom_rd_pkg::*;
;
    localparam logic [3:0] DTYPE = 4'h6; // Device type code, value arbitrary
    logic clk, srst, wr_ready, sda_out, sda_oe, scl, m_low, r, ak;
    logic [2:0] pins;
    logic [7:0] q;
    logic [ADDR_W-1:0] mem_addr;
    logic [WQ_W-1:0] wr_data;
    logic wr_valid;
    int failures, total_checks, cycles, n;
    function automatic logic [7:0] f(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ {a[14:8], 1'b1};
    endfunction : f
    // Pulled-up open-drain data wire and memory array contents
    wire sda = !m_low && !(sda_oe && !sda_out);
    wire logic [DATA_W-1:0] mem_rdata = f(mem_addr);
    eeprom_read_seq #(.DEV_TYPE(DTYPE)) dut_u (.clk(clk), .srst(srst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pin_0(pins[0]),
        .chip_select_pin_1(pins[1]), .chip_select_pin_2(pins[2]), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready));
    two_wire_master m_u (.scl(scl), .sda_low(m_low), .sda(sda));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    // Select byte; ak high when acknowledged
    task automatic sel(input logic [2:0] cs, input logic rw);
        m_u.xfer({DTYPE, cs, rw}, 1'b1, q, r);
        ak = !r;
    endtask : sel
    // Dummy write of a 16-bit address, then restart as a read
    task automatic seek(input logic [15:0] a);
        m_u.start();
        sel(pins, 1'b0);
        m_u.xfer(a[15:8], 1'b1, q, r);
        m_u.xfer(a[7:0], 1'b1, q, r);
        m_u.start();
        sel(pins, 1'b1);
        chk("read select ack", 32'h1, 32'(ak));
    endtask : seek
    // Read one byte, ack it or not, and compare with the array
    task automatic rd(input logic a, input logic [ADDR_W-1:0] ad);
        m_u.xfer(8'hff, !a, q, r);
        chk("read byte", 32'(f(ad)), 32'(q));
        if (!a) chk("ack slot released", 32'h1, 32'(r));
    endtask : rd
    task automatic t_random_seq();
        seek(16'h8123);
        rd(1'b1, 15'h0123);
        rd(1'b1, 15'h0124);
        rd(1'b0, 15'h0125);
        m_u.stop();
        chk("counter after stream", 32'h126, 32'(mem_addr));
    endtask : t_random_seq
    task automatic t_current();
        m_u.start();
        sel(pins, 1'b1);
        chk("current select ack", 32'h1, 32'(ak));
        rd(1'b0, 15'h0126);
        m_u.xfer(8'hff, 1'b1, q, r);
        chk("released after noack", 32'hff, 32'(q));
        m_u.stop();
    endtask : t_current
    task automatic t_wrap();
        seek(16'h7fff);
        rd(1'b1, 15'h7fff);
        rd(1'b0, 15'h0000);
        m_u.stop();
    endtask : t_wrap
    // Address load cut short by a repeated START
    task automatic t_abort();
        m_u.start();
        sel(pins, 1'b0);
        m_u.xfer(8'h00, 1'b1, q, r);
        repeat (4) m_u.clk_bit(1'b1, r);
        m_u.start();
        sel(pins, 1'b1);
        chk("select after abort", 32'h1, 32'(ak));
        rd(1'b0, 15'h0001);
        m_u.stop();
    endtask : t_abort
    task automatic t_select();
        for (int c = 0; c < 8; c++) begin
            m_u.start();
            sel(3'(c), 1'b0);
            chk("chip select ack", 32'(c == pins), 32'(ak));
            m_u.stop();
        end
        // Wrong device type with matching chip-select bits
        m_u.start();
        m_u.xfer({DTYPE ^ 4'h1, pins, 1'b1}, 1'b1, q, r);
        chk("type mismatch ack", 32'h1, 32'(r));
        m_u.stop();
    endtask : t_select
    // Fill the write queue until refused, then drain it
    task automatic t_fifo();
        @(posedge clk) #1 wr_ready = 1'b0;
        #1.25; // Link edges off the clock edge
        m_u.start();
        sel(pins, 1'b0);
        m_u.xfer(8'h00, 1'b1, q, r);
        m_u.xfer(8'h10, 1'b1, q, r);
        for (int i = 0; i < 17; i++) begin
            m_u.xfer(8'ha0 + 8'(i), 1'b1, q, r);
            chk("write byte ack", 32'(i < 16), 32'(!r));
        end
        m_u.stop();
        chk("queue head", 32'h0010a0, 32'(wr_data));
        n = 0;
        @(posedge clk) #1 wr_ready = 1'b1;
        repeat (40) begin
            n += int'(wr_valid === 1'b1);
            @(posedge clk);
            #1;
        end
        chk("entries drained", 32'd16, 32'(n));
    endtask : t_fifo
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cut a hung run short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        srst = 1'b1;
        wr_ready = 1'b1;
        pins = 3'b101;
        repeat (8) @(posedge clk);
        #1 srst = 1'b0;
        chk("counter after reset", 32'h0, 32'(mem_addr));
        t_random_seq();
        t_current();
        t_wrap();
        t_abort();
        t_select();
        t_fifo();
        give_verdict();
    end
endmodule : test_serial_eeprom_read_sequencer
`default_nettype wire
